// ### logic/toc_map.vh
`ifndef TOC_MAP_VH
`define TOC_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets on the bus (one 32-bit word each).
// ----------------------------------------------------------------
`define TOC_OFS_CTRL 8'h00
`define TOC_OFS_OUT 8'h04
`define TOC_OFS_IEN 8'h08
`define TOC_OFS_FLAG 8'h0c
`define TOC_OFS_CNT_LO 8'h10
`define TOC_OFS_CNT_HI 8'h14
`define TOC_OFS_CMPA_LO 8'h18
`define TOC_OFS_CMPA_HI 8'h1c
`define TOC_OFS_CMPB_LO 8'h20
`define TOC_OFS_CMPB_HI 8'h24
`define TOC_OFS_PIN 8'h28

// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define TOC_OUT_FOC_A 4
`define TOC_OUT_FOC_B 5
`define TOC_FLAG_OVF 2
`define TOC_PIN_PORT_A 2

// ----------------------------------------------------------------
// Waveform mode codes.
// ----------------------------------------------------------------
`define TOC_WGM_NORMAL 4'h0
`define TOC_WGM_PC8 4'h1
`define TOC_WGM_PC9 4'h2
`define TOC_WGM_PC10 4'h3
`define TOC_WGM_CTC_A 4'h4
`define TOC_WGM_FAST8 4'h5
`define TOC_WGM_FAST9 4'h6
`define TOC_WGM_FAST10 4'h7
`define TOC_WGM_PFC_C 4'h8
`define TOC_WGM_PFC_A 4'h9
`define TOC_WGM_PC_C 4'ha
`define TOC_WGM_PC_A 4'hb
`define TOC_WGM_CTC_C 4'hc
`define TOC_WGM_FAST_C 4'he
`define TOC_WGM_FAST_A 4'hf

// ----------------------------------------------------------------
// Counter limits and output actions.
// ----------------------------------------------------------------
`define TOC_TOP8 16'h00ff
`define TOC_TOP9 16'h01ff
`define TOC_TOP10 16'h03ff
`define TOC_MAX 16'hffff
`define TOC_BOTTOM 16'h0000
`define TOC_ONE 16'h0001
`define TOC_ACT_TOGGLE 2'h1
`define TOC_ACT_CLEAR 2'h2
`define TOC_ACT_SET 2'h3

`endif

// ### logic/toc_top.v
`timescale 1ns/1ns
// How it works
// (RULE1) Each channel compares all 16 counter bits with its active value.
// (RULE2) Match sets the channel flag at the timer tick; enabled flag asks irq.
// (RULE3) Flag clears on interrupt service or written one; zero is ignored.
// (RULE4) Channel A compare value is TOP in its selected modes.
// (RULE5) Compare value double buffered in PWM modes, direct in normal and CLEAR_ON_MATCH_MODE.
// (RULE6) Buffered value moves to active register only at TOP or BOTTOM.
// (RULE7) CPU accesses reach buffer when buffering, else the active register.
// (RULE8) Compare value changes only on CPU writes; high byte read directly.
// (RULE9) High byte write loads shared latch; low write commits all 16 bits.
// (RULE10) Forced compare in non-PWM modes acts on output only, no flag.
// (RULE11) Counter write blocks every match at the next timer tick.
// (RULE12) Counter written equal to variable TOP misses TOP, runs to 0xFFFF.
// (RULE13) Output latch keeps its value across mode changes.
// (RULE14) Output action setting is unbuffered and acts at next match.
// (RULE15) Reset clears the output latch to zero.
// (RULE16) Nonzero action replaces port data; direction bit still gates pin.
// (RULE17) Action zero leaves the output latch untouched on matches.
// (RULE18) Output action has no effect on input capture.
// (RULE19) Normal mode only counts up and wraps 0xFFFF to 0x0000.
// (RULE20) Normal mode sets overflow flag as counter becomes zero.
// (RULE21) Servicing the overflow interrupt clears the overflow flag.
// (RULE22) Software sets the output latch before making the pin an output.
// (RULE23) One shared 8-bit latch holds the upper byte for 16-bit access.
// (RULE24) Non-PWM actions 1, 2, 3 toggle, clear and set the latch.
`include "toc_map.vh"

module toc_top
(
    input wire clk,
    input wire rst_n,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire timerTick,
    input wire [15:0] captureValue,
    input wire irqAckCmpA,
    input wire irqAckCmpB,
    input wire irqAckOvf,
    output reg irqCmpA,
    output reg irqCmpB,
    output reg irqOvf,
    output reg ocPinA,
    output reg ocPinAOe,
    output reg ocPinB,
    output reg ocPinBOe
);

// ----------------------------------------------------------------
// Bus decode
// ----------------------------------------------------------------
wire reqNew;
wire wrEn;
wire [7:0] wd;
reg [7:0] rdData;
reg [3:0] mode_r;
reg [3:0] actSel_r;
reg [2:0] irqEn_r;
reg [3:0] pinCtl_r;
reg [7:0] hiLatch_r;
reg [15:0] cnt_r;
reg [15:0] cntNxt;
reg dirDown_r;
reg dirNxt;
reg block_r;
reg ovf_r;
wire [31:0] cmpRd;
wire [1:0] flagAll;
wire [1:0] latAll;

// A request is answered one cycle after it appears; writes act at
// the edge where the master sees the ack, so an early release of
// the strobe never leaves a half-done write behind.
assign reqNew = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign wrEn = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
assign wd = wb_dat_i[7:0];

wire wrCtrl = wrEn & (wb_adr_i == `TOC_OFS_CTRL);
wire wrOut = wrEn & (wb_adr_i == `TOC_OFS_OUT);
wire wrIen = wrEn & (wb_adr_i == `TOC_OFS_IEN);
wire wrFlag = wrEn & (wb_adr_i == `TOC_OFS_FLAG);
wire wrPin = wrEn & (wb_adr_i == `TOC_OFS_PIN);
wire wrCntLo = wrEn & (wb_adr_i == `TOC_OFS_CNT_LO);
wire wrAnyHi = wrEn & ((wb_adr_i == `TOC_OFS_CNT_HI)
    | (wb_adr_i == `TOC_OFS_CMPA_HI) | (wb_adr_i == `TOC_OFS_CMPB_HI));
wire rdCntLo = reqNew & ~wb_we_i & (wb_adr_i == `TOC_OFS_CNT_LO);
wire [1:0] wrCmpLo;
assign wrCmpLo[0] = wrEn & (wb_adr_i == `TOC_OFS_CMPA_LO);
assign wrCmpLo[1] = wrEn & (wb_adr_i == `TOC_OFS_CMPB_LO);

// ----------------------------------------------------------------
// Mode decode
// ----------------------------------------------------------------
reg [15:0] topVal;
reg isPwm;
reg isDual;
reg bufAtBot;
reg aIsTop;
wire [15:0] cmpActA;

// Selects the TOP source and counting class for each mode.
always @*
begin
    topVal = `TOC_MAX;
    isPwm = 1'b1;
    isDual = 1'b0;
    bufAtBot = 1'b0;
    aIsTop = 1'b0;
    case (mode_r)
        `TOC_WGM_NORMAL: isPwm = 1'b0; // RULE5 RULE19
        `TOC_WGM_CTC_A:
        begin
            isPwm = 1'b0;
            topVal = cmpActA; // RULE4
            aIsTop = 1'b1;
        end
        `TOC_WGM_CTC_C:
        begin
            isPwm = 1'b0;
            topVal = captureValue;
        end
        `TOC_WGM_PC8:
        begin
            isDual = 1'b1;
            topVal = `TOC_TOP8;
        end
        `TOC_WGM_PC9:
        begin
            isDual = 1'b1;
            topVal = `TOC_TOP9;
        end
        `TOC_WGM_PC10:
        begin
            isDual = 1'b1;
            topVal = `TOC_TOP10;
        end
        `TOC_WGM_FAST8: topVal = `TOC_TOP8;
        `TOC_WGM_FAST9: topVal = `TOC_TOP9;
        `TOC_WGM_FAST10: topVal = `TOC_TOP10;
        `TOC_WGM_FAST_C: topVal = captureValue;
        `TOC_WGM_FAST_A:
        begin
            topVal = cmpActA; // RULE4
            aIsTop = 1'b1;
        end
        `TOC_WGM_PFC_C:
        begin
            isDual = 1'b1;
            bufAtBot = 1'b1;
            topVal = captureValue;
        end
        `TOC_WGM_PFC_A:
        begin
            isDual = 1'b1;
            bufAtBot = 1'b1;
            topVal = cmpActA;
            aIsTop = 1'b1;
        end
        `TOC_WGM_PC_C:
        begin
            isDual = 1'b1;
            topVal = captureValue;
        end
        `TOC_WGM_PC_A:
        begin
            isDual = 1'b1;
            topVal = cmpActA;
            aIsTop = 1'b1;
        end
        default: topVal = `TOC_MAX;
    endcase
end

wire atTop = (cnt_r == topVal);
wire atBot = (cnt_r == `TOC_BOTTOM);
// A blocked tick also hides the TOP match, so a counter written onto
// a variable TOP runs on to the wrap point.
wire topHit = timerTick & atTop & ~block_r; // RULE11 RULE12
wire bufLoad = timerTick & isPwm
    & (bufAtBot ? (atBot & dirDown_r) : atTop); // RULE6
wire botEvt = isPwm & ~isDual & topHit;

// ----------------------------------------------------------------
// Counter
// ----------------------------------------------------------------
// Next count per class; a CPU write has priority over counting.
always @*
begin
    cntNxt = cnt_r;
    dirNxt = dirDown_r;
    if (!isDual)
    begin
        dirNxt = 1'b0;
        if (isPwm | (mode_r != `TOC_WGM_NORMAL))
            cntNxt = topHit ? `TOC_BOTTOM : cnt_r + `TOC_ONE;
        else
            cntNxt = cnt_r + `TOC_ONE; // RULE19
    end
    else if (!dirDown_r)
    begin
        if (topHit)
        begin
            cntNxt = cnt_r - `TOC_ONE;
            dirNxt = 1'b1;
        end
        else
            cntNxt = cnt_r + `TOC_ONE;
    end
    else if (atBot)
    begin
        cntNxt = cnt_r + `TOC_ONE;
        dirNxt = 1'b0;
    end
    else
        cntNxt = cnt_r - `TOC_ONE;
end

// Overflow: wrap in non-PWM, TOP in fast PWM, BOTTOM in dual slope.
wire ovfSet = timerTick & (isDual ? (dirDown_r & atBot)
    : (isPwm ? topHit : (cnt_r == `TOC_MAX))); // RULE20
wire ovfClr = (wrFlag & wd[`TOC_FLAG_OVF]) | irqAckOvf; // RULE21

// Counter, block flag and shared high-byte latch.
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        cnt_r <= `TOC_BOTTOM;
        dirDown_r <= 1'b0;
        block_r <= 1'b0;
        ovf_r <= 1'b0;
        hiLatch_r <= 8'h00;
    end
    else
    begin
        if (wrCntLo)
        begin
            cnt_r <= {hiLatch_r, wd}; // RULE9
            block_r <= 1'b1; // RULE11
        end
        else
        begin
            if (timerTick)
            begin
                cnt_r <= cntNxt;
                dirDown_r <= dirNxt;
                block_r <= 1'b0;
            end
        end
        // Set wins over clear so a coinciding event is kept.
        ovf_r <= (ovf_r & ~ovfClr) | ovfSet; // RULE20
        if (wrAnyHi)
            hiLatch_r <= wd; // RULE9 RULE23
        else if (rdCntLo)
            hiLatch_r <= cnt_r[15:8]; // RULE23
    end
end

// ----------------------------------------------------------------
// Compare channels
// ----------------------------------------------------------------
genvar i;
generate
    for (i = 0; i < 2; i = i + 1)
    begin : gCh
        reg [15:0] act_r;
        reg [15:0] buf_r;
        reg flag_r;
        reg lat_r;
        reg latNxt;
        // A new action acts at once, so a force strobe written together
        // with it already uses the new action.
        wire [1:0] act = wrOut ? wd[2*i+1:2*i] : actSel_r[2*i+1:2*i];
        wire match = timerTick & ~block_r & (cnt_r == act_r); // RULE1
        wire frc = wrOut & wd[`TOC_OUT_FOC_A + i] & ~isPwm; // RULE10
        wire clr = (wrFlag & wd[i])
            | ((i == 0) ? irqAckCmpA : irqAckCmpB); // RULE3
        wire togOk = (i == 0) & aIsTop;

        // Waveform action; action zero never touches the latch.
        always @*
        begin
            latNxt = lat_r; // RULE13 RULE17
            if (!isPwm)
            begin
                if (match | frc)
                begin
                    case (act) // RULE14 RULE24
                        `TOC_ACT_TOGGLE: latNxt = ~lat_r;
                        `TOC_ACT_CLEAR: latNxt = 1'b0;
                        `TOC_ACT_SET: latNxt = 1'b1;
                        default: latNxt = lat_r;
                    endcase
                end
            end
            else
            begin
                if (match)
                begin
                    case (act)
                        `TOC_ACT_TOGGLE: latNxt = togOk ? ~lat_r : lat_r;
                        `TOC_ACT_CLEAR: latNxt = isDual & dirDown_r;
                        `TOC_ACT_SET: latNxt = ~(isDual & dirDown_r);
                        default: latNxt = lat_r;
                    endcase
                end
                if (botEvt & (act == `TOC_ACT_CLEAR))
                    latNxt = 1'b1;
                if (botEvt & (act == `TOC_ACT_SET))
                    latNxt = 1'b0;
            end
        end

        // Only the CPU writes the compare value; hardware only moves
        // the buffer into the active register.
        always @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                act_r <= `TOC_BOTTOM;
                buf_r <= `TOC_BOTTOM;
                flag_r <= 1'b0;
                lat_r <= 1'b0; // RULE15
            end
            else
            begin
                if (wrCmpLo[i])
                begin
                    buf_r <= {hiLatch_r, wd}; // RULE8 RULE9
                    if (!isPwm)
                        act_r <= {hiLatch_r, wd}; // RULE5 RULE7
                end
                else if (bufLoad)
                    act_r <= buf_r; // RULE6
                flag_r <= (flag_r & ~clr) | match; // RULE2 RULE3
                lat_r <= latNxt;
            end
        end

        assign cmpRd[16*i+15:16*i] = isPwm ? buf_r : act_r; // RULE7
        assign flagAll[i] = flag_r;
        assign latAll[i] = lat_r;
        if (i == 0)
        begin : gTop
            assign cmpActA = act_r;
        end
    end
endgenerate

// ----------------------------------------------------------------
// Control registers and read mux
// ----------------------------------------------------------------
// Force bits are strobes and read back as zero.
always @*
begin
    case (wb_adr_i)
        `TOC_OFS_CTRL: rdData = {4'h0, mode_r};
        `TOC_OFS_OUT: rdData = {4'h0, actSel_r};
        `TOC_OFS_IEN: rdData = {5'h00, irqEn_r};
        `TOC_OFS_FLAG: rdData = {5'h00, ovf_r, flagAll};
        `TOC_OFS_PIN: rdData = {4'h0, pinCtl_r};
        `TOC_OFS_CNT_LO: rdData = cnt_r[7:0];
        `TOC_OFS_CNT_HI: rdData = hiLatch_r;
        `TOC_OFS_CMPA_LO: rdData = cmpRd[7:0];
        `TOC_OFS_CMPA_HI: rdData = cmpRd[15:8]; // RULE8
        `TOC_OFS_CMPB_LO: rdData = cmpRd[23:16];
        `TOC_OFS_CMPB_HI: rdData = cmpRd[31:24]; // RULE8
        default: rdData = 8'h00;
    endcase
end

// Bus answer plus the plain control fields.
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
        mode_r <= `TOC_WGM_NORMAL;
        actSel_r <= 4'h0;
        irqEn_r <= 3'h0;
        pinCtl_r <= 4'h0;
    end
    else
    begin
        wb_ack_o <= reqNew;
        wb_dat_o <= reqNew ? {24'h000000, rdData} : 32'h00000000;
        if (wrCtrl)
            mode_r <= wd[3:0]; // RULE13
        if (wrOut)
            actSel_r <= wd[3:0]; // RULE14 RULE18
        if (wrIen)
            irqEn_r <= wd[2:0];
        if (wrPin)
            pinCtl_r <= wd[3:0];
    end
end

// ----------------------------------------------------------------
// Interrupt requests and pins
// ----------------------------------------------------------------
// Nonzero action hands the pin to the latch; direction still rules.
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        irqCmpA <= 1'b0;
        irqCmpB <= 1'b0;
        irqOvf <= 1'b0;
        ocPinA <= 1'b0;
        ocPinAOe <= 1'b0;
        ocPinB <= 1'b0;
        ocPinBOe <= 1'b0;
    end
    else
    begin
        irqCmpA <= flagAll[0] & irqEn_r[0]; // RULE2
        irqCmpB <= flagAll[1] & irqEn_r[1]; // RULE2
        irqOvf <= ovf_r & irqEn_r[2];
        ocPinA <= (actSel_r[1:0] != 2'h0) ? latAll[0]
            : pinCtl_r[`TOC_PIN_PORT_A]; // RULE16 RULE22
        ocPinAOe <= pinCtl_r[0]; // RULE16
        ocPinB <= (actSel_r[3:2] != 2'h0) ? latAll[1]
            : pinCtl_r[`TOC_PIN_PORT_A + 1]; // RULE16
        ocPinBOe <= pinCtl_r[1]; // RULE16
    end
end

endmodule // toc_top

// ### sim/toc_cpu_model.sv
`timescale 1ns/1ns
// ------------------------------------------------
// CPU core model: bus master and interrupt service.
// ------------------------------------------------
module toc_cpu_model
(
    input wire clk,
    input wire ack,
    output reg [7:0] adr,
    output reg [31:0] dat,
    output reg [3:0] sel,
    output reg we,
    output reg cyc,
    output reg stb,
    output reg [2:0] svcAck
);
    // Idle bus and no service pulses from time zero.
    initial {adr, dat, sel, we, cyc, stb, svcAck} = 0;

    // One classic cycle, held until ack is sampled high.
    task xfer(input w, input [7:0] a, input [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        sel <= 4'h1;
        do @(posedge clk); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        // Released data lines show junk, not the last value.
        dat <= ~dat;
    endtask

    // Interrupt service after a prompt or slow delay.
    task svc(input integer n, input integer dly);
        repeat (dly) @(posedge clk);
        svcAck[n] <= 1'b1;
        @(posedge clk);
        svcAck[n] <= 1'b0;
    endtask
endmodule // toc_cpu_model

// ### sim/toc_top_asserts.sv
`timescale 1ns/1ns
// ------------------------------------------------
// Port-level checks on the output compare block.
// ------------------------------------------------
module toc_top_asserts
(
    input wire clk,
    input wire rst_n,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire timerTick,
    input wire irqAckCmpA,
    input wire irqAckOvf,
    input wire irqCmpA,
    input wire irqOvf,
    input wire ocPinA,
    input wire ocPinAOe
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // A write landing at this edge; pins and interrupts may follow it.
    wire busWr = wb_ack_o && wb_we_i && wb_cyc_i;

    // Request steps of one classic bus cycle.
    sequence reqSeen;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ackOnce;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    ack_one_pulse_a: assert property (reqSeen |=> ackOnce)
        else $error("Bus request not answered by one ack pulse.");
    read_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("Read data not zero outside ack.");
    reset_pins_low_a: assert property (
        $rose(rst_n) |-> !ocPinA && !ocPinAOe && !irqCmpA && !irqOvf)
        else $error("Outputs not low after reset.");
    pin_dir_cause_a: assert property (
        $changed(ocPinAOe) |-> $past(busWr) || $past(busWr, 2))
        else $error("Pin enable changed without a bus write.");
    pin_data_cause_a: assert property (
        $changed(ocPinA) |-> $past(busWr) || $past(busWr, 2) ||
        $past(timerTick) || $past(timerTick, 2))
        else $error("Pin data changed without a write or a tick.");
    irq_rise_cause_a: assert property (
        $rose(irqCmpA) |-> $past(timerTick) || $past(busWr) ||
        $past(timerTick, 2) || $past(busWr, 2))
        else $error("Compare interrupt rose without a cause.");
    cmpa_ack_clear_a: assert property (
        irqAckCmpA && !timerTick |-> ##2 !irqCmpA)
        else $error("Serviced compare interrupt still pending.");
    ovf_ack_clear_a: assert property (
        irqAckOvf && !timerTick |-> ##2 !irqOvf)
        else $error("Serviced overflow interrupt still pending.");
    ovf_fall_cause_a: assert property (
        $fell(irqOvf) |-> $past(irqAckOvf) || $past(irqAckOvf, 2) ||
        $past(busWr) || $past(busWr, 2))
        else $error("Overflow interrupt fell without service.");
endmodule // toc_top_asserts

bind toc_top toc_top_asserts toc_top_asserts_inst
(
    .clk, .rst_n, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
    .timerTick, .irqAckCmpA, .irqAckOvf, .irqCmpA, .irqOvf, .ocPinA,
    .ocPinAOe
);

// ### sim/toc_top_test.sv
`timescale 1ns/1ns
`include "toc_map.vh"
// ------------------------------------------------
// Self-checking bench for the output compare block.
// ------------------------------------------------
module toc_top_test;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg timerTick = 1'b0;
    reg [15:0] captureValue = 16'h0000;
    integer seed = 32'h239b4cc1;
    integer fails = 0;
    integer nCompared = 0;
    integer cycles = 0;
    integer i;
    reg [15:0] rv;
    reg [31:0] expQ[$];
    wire [7:0] adr;
    wire [31:0] datI, datO;
    wire [3:0] sel;
    wire [2:0] svcAck;
    wire we, cyc, stb, ack, irqA, irqB, irqO, pinA, oeA, pinB, oeB;

    toc_top toc_top_inst
    (
        .clk(clk), .rst_n(rst_n), .wb_adr_i(adr), .wb_dat_i(datI),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(datO), .wb_ack_o(ack), .timerTick(timerTick),
        .captureValue(captureValue), .irqAckCmpA(svcAck[0]),
        .irqAckCmpB(svcAck[1]), .irqAckOvf(svcAck[2]), .irqCmpA(irqA),
        .irqCmpB(irqB), .irqOvf(irqO), .ocPinA(pinA), .ocPinAOe(oeA),
        .ocPinB(pinB), .ocPinBOe(oeB)
    );
    toc_cpu_model toc_cpu_model_inst
    (
        .clk(clk), .ack(ack), .adr(adr), .dat(datI), .sel(sel), .we(we),
        .cyc(cyc), .stb(stb), .svcAck(svcAck)
    );

    // Free-running 20 MHz clock.
    initial forever #25 clk = ~clk;

    task giveVerdict;
        $display("Compared %0d, mismatches %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        nCompared = nCompared + 1;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
            fails = fails + 1;
        end
    endtask

    // Pins and interrupts are registered behind the written fields, so
    // two edges pass before anyone looks at them.
    task wr(input [7:0] a, input [7:0] d);
        toc_cpu_model_inst.xfer(1'b1, a, d);
        repeat (2) @(posedge clk);
    endtask

    // The expected value is queued; the monitor compares it later.
    task rd(input [7:0] a, input [7:0] e);
        expQ.push_back({24'h0, e});
        toc_cpu_model_inst.xfer(1'b0, a, 8'h00);
    endtask

    // High byte first, so the low write commits all 16 bits.
    task w16(input [7:0] lo, input [15:0] v);
        wr(lo + 8'h04, v[15:8]);
        wr(lo, v[7:0]);
    endtask

    // Timer clock pulses, then time for flags and pins to settle.
    task tick(input integer n);
        repeat (n)
        begin
            @(posedge clk);
            timerTick <= 1'b1;
            @(posedge clk);
            timerTick <= 1'b0;
        end
        repeat (2) @(posedge clk);
    endtask

    // Each read answer is matched against the oldest expected value.
    always @(posedge clk)
        if (ack === 1'b1 && we === 1'b0)
            chk(datO, expQ.pop_front());

    // A hang is cut short well beyond the expected run length.
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 5000)
        begin
            fails = fails + 1;
            giveVerdict;
        end
    end

    // Main sequence.
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        chk({31'h0, pinA}, 32'h0);
        rd(`TOC_OFS_FLAG, 8'h00);
        rd(8'h2c, 8'h00);
        // Shared high latch; compare high byte is read directly.
        rv = $random(seed);
        w16(`TOC_OFS_CMPA_LO, rv);
        wr(`TOC_OFS_CMPB_HI, ~rv[15:8]);
        wr(`TOC_OFS_CMPB_LO, rv[7:0]);
        rd(`TOC_OFS_CMPA_LO, rv[7:0]);
        rd(`TOC_OFS_CMPA_HI, rv[15:8]);
        rd(`TOC_OFS_CMPB_HI, ~rv[15:8]);
        // Latch set by force before the pin is made an output.
        wr(`TOC_OFS_OUT, 8'h11);
        wr(`TOC_OFS_PIN, 8'h01);
        chk({30'h0, oeA, pinA}, 32'h3);
        wr(`TOC_OFS_OUT, 8'h00);
        chk({31'h0, pinA}, 32'h0);
        wr(`TOC_OFS_PIN, 8'h0f);
        chk({29'h0, oeB, pinB, pinA}, 32'h7);
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(`TOC_OFS_OUT, (i < 2) ? 8'h12 + i[7:0] : 8'h11);
            chk({31'h0, pinA}, {31'h0, i[0]});
        end
        rd(`TOC_OFS_FLAG, 8'h00);
        // Mode changes keep the latch; force is ignored in PWM.
        wr(`TOC_OFS_CTRL, 8'h04);
        wr(`TOC_OFS_CTRL, 8'h05);
        wr(`TOC_OFS_OUT, 8'h12);
        wr(`TOC_OFS_CTRL, 8'h00);
        wr(`TOC_OFS_OUT, 8'h01);
        chk({31'h0, pinA}, 32'h1);
        // A counter write blocks the next match only.
        wr(`TOC_OFS_IEN, 8'h07);
        w16(`TOC_OFS_CMPA_LO, 16'h1234);
        w16(`TOC_OFS_CMPB_LO, 16'h1236);
        w16(`TOC_OFS_CNT_LO, 16'h1234);
        tick(2);
        rd(`TOC_OFS_FLAG, 8'h00);
        tick(1);
        rd(`TOC_OFS_FLAG, 8'h02);
        w16(`TOC_OFS_CMPA_LO, 16'h1237);
        tick(1);
        chk({29'h0, irqB, irqA, pinA}, 32'h6);
        wr(`TOC_OFS_FLAG, 8'h00);
        rd(`TOC_OFS_FLAG, 8'h03);
        toc_cpu_model_inst.svc(0, 3);
        rd(`TOC_OFS_FLAG, 8'h02);
        wr(`TOC_OFS_FLAG, 8'h02);
        rd(`TOC_OFS_FLAG, 8'h00);
        chk({30'h0, irqB, irqA}, 32'h0);
        // Wrap to zero sets the overflow flag, held until serviced.
        w16(`TOC_OFS_CNT_LO, 16'hffff);
        tick(1);
        rd(`TOC_OFS_CNT_LO, 8'h00);
        rd(`TOC_OFS_CNT_HI, 8'h00);
        tick(2);
        rd(`TOC_OFS_FLAG, 8'h04);
        chk({31'h0, irqO}, 32'h1);
        toc_cpu_model_inst.svc(2, 0);
        rd(`TOC_OFS_FLAG, 8'h00);
        // Action zero leaves the latch alone on a real match.
        wr(`TOC_OFS_OUT, 8'h00);
        w16(`TOC_OFS_CNT_LO, 16'h1236);
        tick(2);
        wr(`TOC_OFS_OUT, 8'h01);
        rd(`TOC_OFS_FLAG, 8'h01);
        chk({31'h0, pinA}, 32'h0);
        giveVerdict;
    end
endmodule // toc_top_test
